/* rtl/ctrl_regs_pkg.sv */
// Purpose: Shared constants and types for the controller register bank.
// Assumes: APB with 32-bit data and a 12-bit byte address.
// Notes:   Every offset, field position and reset value lives here.

package ctrl_regs_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] OFF_SPEC_VERSION   = 12'h008;
    localparam logic [11:0] OFF_MASK_SET       = 12'h00c;
    localparam logic [11:0] OFF_MASK_CLEAR     = 12'h010;
    localparam logic [11:0] OFF_CTRL_CONFIG    = 12'h014;
    localparam logic [11:0] OFF_EVENT_STATUS   = 12'h040;
    localparam logic [11:0] OFF_EVENT_MASK     = 12'h044;

    // ************************************************************
    // Version register fields
    // ************************************************************
    localparam logic [15:0] MAJOR_REVISION_VAL = 16'h0001;
    localparam logic [7:0]  MINOR_REVISION_VAL = 8'h02;
    localparam logic [7:0]  VERSION_RSVD_VAL   = 8'h00;
    localparam logic [31:0] SPEC_VERSION_VAL   =
        {MAJOR_REVISION_VAL, MINOR_REVISION_VAL, VERSION_RSVD_VAL};

    // ************************************************************
    // Configuration register fields
    // ************************************************************
    localparam int          CC_CQ_EXP_LSB      = 20;
    localparam int          CC_SQ_EXP_LSB      = 16;
    localparam logic [3:0]  ENTRY_EXP_RESET    = 4'h0;

    // ************************************************************
    // Interrupt vector mask and event status
    // ************************************************************
    localparam int          VECTOR_COUNT       = 32;
    localparam logic [31:0] VECTOR_MASK_RESET  = 32'h0000_0000;
    localparam int          EVENT_COUNT        = 2;
    localparam int          EV_QUEUE_REJECT    = 0;
    localparam int          EV_MSIX_ACCESS     = 1;
    localparam logic [1:0]  EVENT_RESET        = 2'h0;

    typedef struct packed {
        logic [7:0]  rsvd_hi;
        logic [3:0]  completion_entry_size_exp;
        logic [3:0]  submission_entry_size_exp;
        logic [15:0] rsvd_lo;
    } cc_t;

    typedef struct packed {
        logic valid;
        logic is_completion;
    } queue_create_t;

endpackage : ctrl_regs_pkg

/* rtl/bit_set_clear.sv */
// Purpose: Bank of flags with per-bit set and clear strobes.
// Assumes: Synchronous active-high reset.
// Notes:   A set and a clear of the same bit in one cycle leaves it set.

`timescale 1ns/1ps
`default_nettype none

module bit_set_clear #(
    parameter int          WIDTH     = 32,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    input  wire logic             core_clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output var  logic [WIDTH-1:0] bits_o
);

    wire logic [WIDTH-1:0] next_bits = (bits_o & ~clr_i) | set_i;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            bits_o <= RESET_VAL[WIDTH-1:0];
        end else begin
            bits_o <= next_bits;
        end
    end

endmodule : bit_set_clear

`default_nettype wire

/* rtl/ctrl_version_mask_config_regs.sv */
// Purpose: Version, interrupt vector mask and queue entry size registers.
// Assumes: APB slave, zero wait states; all inputs on core_clk_i.
// Notes:   Event status is sticky, write one to clear, gated by a mask.
//
// Overview of operation
// - Version reads major value 1 in bits 31:16, reserved low byte zero.
// - Version reads minor value 2 in bits 15:8, read only.
// - Outside MSI-X mode, writing one to a mask-set bit masks that vector; mask resets to zero.
// - Outside MSI-X mode, writing one to a mask-clear bit unmasks that vector in shared mask.
// - Zero bits written to either mask register leave the mask unchanged.
// - Reading either mask register returns the live internal mask.
// - Mask applies only outside MSI-X mode; MSI-X bypasses it.
// - Queue creation with unset entry size is rejected as invalid size.
// - Submission entry exponent in bits 19:16, read-write, resets zero.

`timescale 1ns/1ps
`default_nettype none

module ctrl_version_mask_config_regs
    import ctrl_regs_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  srst_i,
    // APB slave
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [APB_ADDR_W-1:0] paddr_i,
    input  wire logic [APB_DATA_W-1:0] pwdata_i,
    output var  logic [APB_DATA_W-1:0] prdata_o,
    output var  logic                  pready_o,
    output var  logic                  pslverr_o,
    // Controller side
    input  wire logic                  msix_mode_i,
    input  wire logic [VECTOR_COUNT-1:0] vector_req_i,
    output var  logic [VECTOR_COUNT-1:0] vector_assert_o,
    input  wire queue_create_t         create_i,
    output var  logic                  create_done_o,
    output var  logic                  create_reject_o,
    output var  logic [3:0]            completion_entry_size_exp_o,
    output var  logic [3:0]            submission_entry_size_exp_o,
    output var  logic                  irq_o
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire logic setup_phase  = psel_i & ~penable_i;
    wire logic access_fire  = psel_i & penable_i & pready_o;
    wire logic wr_fire      = access_fire & pwrite_i;
    wire logic rd_fire      = access_fire & ~pwrite_i;

    wire logic sel_version  = (paddr_i == OFF_SPEC_VERSION);
    wire logic sel_mset     = (paddr_i == OFF_MASK_SET);
    wire logic sel_mclr     = (paddr_i == OFF_MASK_CLEAR);
    wire logic sel_cc       = (paddr_i == OFF_CTRL_CONFIG);
    wire logic sel_evstat   = (paddr_i == OFF_EVENT_STATUS);
    wire logic sel_evmask   = (paddr_i == OFF_EVENT_MASK);
    wire logic sel_mask_any = sel_mset | sel_mclr;
    wire logic mapped       = sel_version | sel_mask_any | sel_cc
                            | sel_evstat | sel_evmask;

    // ************************************************************
    // Shared vector mask
    // ************************************************************
    // Writes while MSI-X is configured are undefined for the host, so the
    // mask is left alone then and the access is flagged instead.
    wire logic mask_wr_ok = wr_fire & ~msix_mode_i;
    wire logic [VECTOR_COUNT-1:0] mask_set_bits =
        (mask_wr_ok & sel_mset) ? pwdata_i : '0;
    wire logic [VECTOR_COUNT-1:0] mask_clr_bits =
        (mask_wr_ok & sel_mclr) ? pwdata_i : '0;
    logic [VECTOR_COUNT-1:0] vector_mask;

    // Zero bits in either write leave the flag untouched.
    bit_set_clear #(
        .WIDTH     (VECTOR_COUNT),
        .RESET_VAL (VECTOR_MASK_RESET)
    ) u_vector_mask (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .set_i      (mask_set_bits),
        .clr_i      (mask_clr_bits),
        .bits_o     (vector_mask)
    );

    // ************************************************************
    // Controller configuration
    // ************************************************************
    logic [3:0] cq_exp;
    logic [3:0] sq_exp;
    wire logic  cc_wr = wr_fire & sel_cc;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cq_exp <= ENTRY_EXP_RESET;
            sq_exp <= ENTRY_EXP_RESET;
        end else if (cc_wr) begin
            cq_exp <= pwdata_i[CC_CQ_EXP_LSB +: 4];
            sq_exp <= pwdata_i[CC_SQ_EXP_LSB +: 4];
        end
    end

    cc_t cc_view;
    assign cc_view = '{rsvd_hi: '0,
                       completion_entry_size_exp: cq_exp,
                       submission_entry_size_exp: sq_exp,
                       rsvd_lo: '0};

    assign completion_entry_size_exp_o = cq_exp;
    assign submission_entry_size_exp_o = sq_exp;

    // ************************************************************
    // Queue creation check
    // ************************************************************
    // An entry size exponent of zero means software never set it up.
    wire logic size_unset  = create_i.is_completion ? (cq_exp == 4'h0)
                                                    : (sq_exp == 4'h0);
    wire logic next_reject = create_i.valid & size_unset;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            create_done_o   <= 1'b0;
            create_reject_o <= 1'b0;
        end else begin
            create_done_o   <= create_i.valid;
            create_reject_o <= next_reject;
        end
    end

    // ************************************************************
    // Vector gating
    // ************************************************************
    // Under MSI-X the per-vector table elsewhere does the masking.
    wire logic [VECTOR_COUNT-1:0] next_vector_assert =
        msix_mode_i ? vector_req_i : (vector_req_i & ~vector_mask);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            vector_assert_o <= '0;
        end else begin
            vector_assert_o <= next_vector_assert;
        end
    end

    // ************************************************************
    // Event status and interrupt
    // ************************************************************
    logic [EVENT_COUNT-1:0] event_status;
    logic [EVENT_COUNT-1:0] event_mask;
    logic [EVENT_COUNT-1:0] event_set;

    assign event_set[EV_QUEUE_REJECT] = next_reject;
    assign event_set[EV_MSIX_ACCESS]  = access_fire & sel_mask_any & msix_mode_i;

    wire logic [EVENT_COUNT-1:0] event_clr =
        (wr_fire & sel_evstat) ? pwdata_i[EVENT_COUNT-1:0] : '0;

    bit_set_clear #(
        .WIDTH     (EVENT_COUNT),
        .RESET_VAL ({30'h0000_0000, EVENT_RESET})
    ) u_event_status (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .set_i      (event_set),
        .clr_i      (event_clr),
        .bits_o     (event_status)
    );

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            event_mask <= EVENT_RESET;
        end else if (wr_fire & sel_evmask) begin
            event_mask <= pwdata_i[EVENT_COUNT-1:0];
        end
    end

    wire logic next_irq = |(event_status & event_mask);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end

    // ************************************************************
    // Read data and response
    // ************************************************************
    // Read data is captured in the setup cycle so every output is a flop;
    // APB never overlaps a write access with a read setup, so a read that
    // follows a write always sees the updated mask.
    wire logic [APB_DATA_W-1:0] next_prdata =
        sel_version  ? SPEC_VERSION_VAL :
        sel_mask_any ? vector_mask :
        sel_cc       ? cc_view :
        sel_evstat   ? {30'h0000_0000, event_status} :
        sel_evmask   ? {30'h0000_0000, event_mask} :
                       32'h0000_0000;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            prdata_o  <= '0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= setup_phase ? next_prdata : '0;
            pready_o  <= setup_phase;
            pslverr_o <= setup_phase & ~mapped;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    a_version_major_read: assert property (
        rd_fire && sel_version |-> prdata_o[31:16] == 16'h0001
                                   && prdata_o[7:0] == 8'h00)
        else $error("Version major or reserved field wrong.");

    a_version_minor_read: assert property (
        setup_phase && sel_version ##1 access_fire |-> prdata_o[15:8] == 8'h02)
        else $error("Version minor field wrong.");

    a_mask_set_bits: assert property (
        wr_fire && sel_mset && !msix_mode_i |=>
            (vector_mask & $past(pwdata_i)) == $past(pwdata_i))
        else $error("Mask set did not mask the written vectors.");

    a_mask_clear_bits: assert property (
        wr_fire && sel_mclr && !msix_mode_i |=>
            (vector_mask & $past(pwdata_i)) == 32'h0000_0000)
        else $error("Mask clear did not unmask the written vectors.");

    a_mask_zero_keep: assert property (
        wr_fire && sel_mask_any |=>
            (vector_mask & ~$past(pwdata_i)) == ($past(vector_mask) & ~$past(pwdata_i)))
        else $error("A zero written bit changed the mask.");

    a_mask_read_live: assert property (
        setup_phase && sel_mask_any ##1 rd_fire |-> prdata_o == vector_mask)
        else $error("Mask read does not show the internal mask.");

    a_masked_no_assert: assert property (
        !msix_mode_i |=> (vector_assert_o & $past(vector_mask)) == 32'h0000_0000)
        else $error("A masked vector was asserted.");

    a_msix_bypass: assert property (
        msix_mode_i |=> vector_assert_o == $past(vector_req_i))
        else $error("MSI-X mode did not bypass the mask.");

    a_msix_access_flag: assert property (
        access_fire && sel_mask_any && msix_mode_i |=>
            event_status[EV_MSIX_ACCESS] && vector_mask == $past(vector_mask))
        else $error("MSI-X mask access not flagged or mask changed.");

    a_queue_reject: assert property (
        create_i.valid && size_unset |=> create_done_o && create_reject_o ##1
            event_status[EV_QUEUE_REJECT])
        else $error("Queue creation with unset size not rejected.");

    a_cc_field_read: assert property (
        cc_wr ##1 setup_phase && sel_cc ##1 rd_fire |->
            prdata_o[31:24] == 8'h00 && prdata_o[23:16] == $past(pwdata_i[23:16], 2)
            && completion_entry_size_exp_o == prdata_o[23:20])
        else $error("Configuration read back wrong.");

    a_sq_exp_hold: assert property (
        !cc_wr |=> $stable(submission_entry_size_exp_o))
        else $error("Submission entry size changed without a write.");

    a_mask_shared: assert property (
        wr_fire && sel_mset && !msix_mode_i ##1 setup_phase && sel_mclr
            ##1 rd_fire |-> (prdata_o & $past(pwdata_i, 2)) == $past(pwdata_i, 2))
        else $error("Mask clear register does not show the set update.");

    a_irq_level: assert property (
        1'b1 |=> irq_o == $past(next_irq))
        else $error("Interrupt output does not follow masked status.");

    a_apb_zero_wait: assert property (
        setup_phase |=> pready_o && (pslverr_o == !$past(mapped)))
        else $error("APB response not in the first access cycle.");

endmodule : ctrl_version_mask_config_regs

`default_nettype wire

/* bench/apb_host_model.sv */
// Purpose: Host software model that reaches the register bank over APB.
// Assumes: The bank answers with pready at some rising edge; no fixed latency.
// Notes:   Released address and data lines are inverted so stale values never pass.

`timescale 1ns/1ps
`default_nettype none

module apb_host_model
    import ctrl_regs_pkg::*;
(
    input  wire logic                  core_clk_i,
    output var  logic                  psel_o,
    output var  logic                  penable_o,
    output var  logic                  pwrite_o,
    output var  logic [APB_ADDR_W-1:0] paddr_o,
    output var  logic [APB_DATA_W-1:0] pwdata_o,
    input  wire logic [APB_DATA_W-1:0] prdata_i,
    input  wire logic                  pready_i,
    input  wire logic                  pslverr_i
);
    // Set when the last transfer kept psel up for a back-to-back setup.
    logic chained;

    initial begin
        chained   = 1'b0;
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 12'h000;
        pwdata_o  = 32'h0000_0000;
    end

    // ************************************************************
    // One transfer: setup, access until pready, then release
    // ************************************************************
    // Callers keep the mask registers alone in MSI-X mode unless a test means it.
    // Only bank fields inside this block are written; enable ordering stays upstream.
    // A kept select lets the next call start its setup at this same edge, so
    // the bank sees a write access followed at once by the next setup.
    task automatic xfer(input logic wr, input logic [APB_ADDR_W-1:0] addr,
                        input logic [APB_DATA_W-1:0] wdata, input logic keep,
                        output logic [APB_DATA_W-1:0] rdata, output logic err);
        if (!chained) begin
            @(posedge core_clk_i);
        end
        chained = 1'b0;
        psel_o   <= 1'b1;
        pwrite_o <= wr;
        paddr_o  <= addr;
        pwdata_o <= wdata;
        @(posedge core_clk_i);
        penable_o <= 1'b1;
        // No latency is assumed; only the bench watchdog ends this wait.
        do begin
            @(posedge core_clk_i);
        end while (pready_i !== 1'b1);
        rdata = prdata_i;
        err   = pslverr_i;
        penable_o <= 1'b0;
        if (keep) begin
            chained = 1'b1;
        end else begin
            psel_o   <= 1'b0;
            paddr_o  <= ~addr;
            pwdata_o <= ~wdata;
        end
    endtask : xfer
endmodule : apb_host_model

`default_nettype wire

/* bench/ctrl_version_mask_config_regs_tb.sv */
// Purpose: Self-checking bench for the version, mask and configuration bank.
// Assumes: A host model drives APB; the bench drives the controller side.
// Notes:   Expected values are worked out by hand from the register layout.

`timescale 1ns/1ps
`default_nettype none

module ctrl_version_mask_config_regs_tb
    import ctrl_regs_pkg::*;
;

    logic                  core_clk_i;
    logic                  srst_i;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
    logic [APB_DATA_W-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  msix_mode;
    logic [31:0]           vector_req;
    logic [31:0]           vector_assert;
    queue_create_t         create;
    logic                  create_done;
    logic                  create_reject;
    logic [3:0]            cq_exp;
    logic [3:0]            sq_exp;
    logic                  irq;
    int                    errors;
    int                    comparisons;

    ctrl_version_mask_config_regs dut (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .msix_mode_i(msix_mode),
        .vector_req_i(vector_req), .vector_assert_o(vector_assert), .create_i(create),
        .create_done_o(create_done), .create_reject_o(create_reject),
        .completion_entry_size_exp_o(cq_exp), .submission_entry_size_exp_o(sq_exp),
        .irq_o(irq));

    apb_host_model host (
        .core_clk_i(core_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    // ************************************************************
    // Shared checking and access tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic keep);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b1, addr, data, keep, r, e);
    endtask : wr

    task automatic rd(input string name, input logic [11:0] addr, input logic [31:0] exp,
                      input logic exp_err);
        logic [31:0] r;
        logic        e;
        host.xfer(1'b0, addr, 32'h0000_0000, 1'b0, r, e);
        check(name, r, exp);
        check({name, "_err"}, {31'h0, e}, {31'h0, exp_err});
    endtask : rd

    // Creation request is taken at one edge; the answer stands the following cycle.
    task automatic make_queue(input logic is_cq, input logic exp_rej);
        @(posedge core_clk_i);
        create <= '{valid: 1'b1, is_completion: is_cq};
        @(posedge core_clk_i);
        create <= '0;
        @(negedge core_clk_i);
        check("create_done", {31'h0, create_done}, 32'h1);
        check("create_reject", {31'h0, create_reject}, {31'h0, exp_rej});
        @(negedge core_clk_i);
        check("create_done_end", {31'h0, create_done}, 32'h0);
    endtask : make_queue

    task automatic settle_check(input string name, input logic [31:0] exp);
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check(name, (name == "irq") ? {31'h0, irq} : vector_assert, exp);
    endtask : settle_check

    task automatic print_verdict();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        errors      = 0;
        comparisons = 0;
        srst_i      = 1'b1;
        msix_mode   = 1'b0;
        vector_req  = 32'h0000_0000;
        create      = '0;
        repeat (10) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd("version", OFF_SPEC_VERSION, 32'h0001_0200, 1'b0);
        rd("mask_reset", OFF_MASK_SET, 32'h0000_0000, 1'b0);
        rd("config_reset", OFF_CTRL_CONFIG, 32'h0000_0000, 1'b0);
        make_queue(1'b0, 1'b1);
        wr(OFF_SPEC_VERSION, 32'hFFFF_FFFF, 1'b0);
        rd("version_ro", OFF_SPEC_VERSION, 32'h0001_0200, 1'b0);
        // Kept select: the read setup follows the write access at once.
        wr(OFF_MASK_SET, 32'hA5A5_0F0F, 1'b1);
        rd("mask_via_clear", OFF_MASK_CLEAR, 32'hA5A5_0F0F, 1'b0);
        wr(OFF_MASK_SET, 32'h0000_00F0, 1'b0);
        rd("mask_set_zeros", OFF_MASK_SET, 32'hA5A5_0FFF, 1'b0);
        wr(OFF_MASK_CLEAR, 32'h8000_0F01, 1'b0);
        rd("mask_clear", OFF_MASK_SET, 32'h25A5_00FE, 1'b0);
        vector_req <= 32'hFFFF_FFFF;
        settle_check("vector_masked", 32'hDA5A_FF01);
        msix_mode <= 1'b1;
        settle_check("vector_msix", 32'hFFFF_FFFF);
        wr(OFF_MASK_CLEAR, 32'hFFFF_FFFF, 1'b0);
        rd("mask_msix_read", OFF_MASK_SET, 32'h25A5_00FE, 1'b0);
        msix_mode <= 1'b0;
        rd("status_events", OFF_EVENT_STATUS, 32'h0000_0003, 1'b0);
        wr(OFF_CTRL_CONFIG, 32'hAB50_1234, 1'b1);
        rd("config_fields", OFF_CTRL_CONFIG, 32'h0050_0000, 1'b0);
        check("cq_exp", {28'h0, cq_exp}, 32'h5);
        check("sq_exp", {28'h0, sq_exp}, 32'h0);
        make_queue(1'b1, 1'b0);
        make_queue(1'b0, 1'b1);
        wr(OFF_EVENT_MASK, 32'h0000_0001, 1'b0);
        wr(OFF_EVENT_STATUS, 32'h0000_0003, 1'b0);
        settle_check("irq", 32'h0);
        make_queue(1'b0, 1'b1);
        settle_check("irq", 32'h1);
        wr(OFF_EVENT_STATUS, 32'h0000_0001, 1'b0);
        settle_check("irq", 32'h0);
        rd("unmapped", 12'h018, 32'h0000_0000, 1'b1);
        print_verdict();
    end

    initial begin
        repeat (5000) @(posedge core_clk_i);
        errors++;
        print_verdict();
    end
endmodule : ctrl_version_mask_config_regs_tb

`default_nettype wire
